// >>> rtl/ebt_phase_len.sv
// Module: phase length calculator, count optionally doubled.
`timescale 1ns/1ps
module ebt_phase_len #(
  parameter int WIDTH = 3
) (
  // Configuration
  input wire logic [WIDTH-1:0] count,
  input wire logic doubler,
  // Result
  output logic [ebt_pkg::CNT_BITS-1:0] cycles
);

  always_comb
  begin
    if (doubler)
      cycles = ebt_pkg::CNT_BITS'({count, 1'b0});
    else
      cycles = ebt_pkg::CNT_BITS'(count);
  end

endmodule : ebt_phase_len

// >>> rtl/ebt_phase_timer.sv
// Module: lead, active and trail phase sequencer for the external bus.
//
// Behaviour
// - Each access runs lead, then active, then trail phase.
// - Every chip-select zone has its own timing configuration.
// - Read lead lasts read_lead_count, doubled when timing_doubler set, at least one cycle.
// - Read active lasts read_active_count (doubled) plus waits plus one.
// - Read trail lasts read_trail_count, doubled when timing_doubler set.
// - Write lead lasts write_lead_count, doubled when timing_doubler set, at least one cycle.
// - Write active lasts write_active_count (doubled) plus waits plus one.
// - Write trail lasts write_trail_count, doubled when timing_doubler set.
// - No legality check on settings; no error is raised.
// - Inserted waits come from ready_input during active phase.
// - Inserted waits are zero when ready_use_enable is cleared.
// - Lead starts on external clock rising edge, after one or more align cycles.
// - Strobes change only on timing clock edges at phase boundaries.
`timescale 1ns/1ps
module ebt_phase_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Timing clock enable and external clock mode
  input wire logic timing_clock_en,
  input wire logic external_clock_half,
  // Zone configuration
  input wire ebt_pkg::ebt_zone_timing_config_type
    zone_timing_config [ebt_pkg::ZONE_COUNT],
  // Access request
  input wire ebt_pkg::ebt_request_type request,
  output logic request_ready,
  // External pins
  input wire logic ready_input,
  output logic external_clock_output,
  output ebt_pkg::ebt_strobes_type strobes,
  // Status
  output logic busy,
  output logic access_done,
  output logic [ebt_pkg::CNT_BITS-1:0] inserted_wait_count
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ebt_pkg::ebt_state_type state;
    logic write;
    logic [ebt_pkg::ZONE_BITS-1:0] zone;
    logic [ebt_pkg::CNT_BITS-1:0] cnt;
    logic [ebt_pkg::CNT_BITS-1:0] waits;
    logic xclk;
    logic rdy_meta;
    logic rdy_sync;
    logic done;
    ebt_pkg::ebt_strobes_type strobes;
  } ebt_timer_state_type;

  ebt_timer_state_type s_q;
  ebt_timer_state_type s_d;

  ebt_pkg::ebt_zone_timing_config_type cfg;
  logic [ebt_pkg::CNT_BITS-1:0] lead_len;
  logic [ebt_pkg::CNT_BITS-1:0] active_len;
  logic [ebt_pkg::CNT_BITS-1:0] trail_len;
  logic [ebt_pkg::ACTIVE_BITS-1:0] active_sel;
  logic [ebt_pkg::LEAD_BITS-1:0] lead_sel;
  logic [ebt_pkg::TRAIL_BITS-1:0] trail_sel;
  logic xclk_next;
  logic rise_next;
  logic not_ready;

  // Configuration of the zone being served, not checked for legality.
  assign cfg = zone_timing_config[s_q.zone];
  assign lead_sel = s_q.write ? cfg.write_lead_count : cfg.read_lead_count;
  assign active_sel = s_q.write ? cfg.write_active_count
                                : cfg.read_active_count;
  assign trail_sel = s_q.write ? cfg.write_trail_count
                               : cfg.read_trail_count;

  // ---------------------------------------------------------------
  // Phase lengths
  // ---------------------------------------------------------------
  ebt_phase_len #(.WIDTH(ebt_pkg::LEAD_BITS)) u_lead (
    .count(lead_sel),
    .doubler(cfg.timing_doubler),
    .cycles(lead_len)
  );

  ebt_phase_len #(.WIDTH(ebt_pkg::ACTIVE_BITS)) u_active (
    .count(active_sel),
    .doubler(cfg.timing_doubler),
    .cycles(active_len)
  );

  ebt_phase_len #(.WIDTH(ebt_pkg::TRAIL_BITS)) u_trail (
    .count(trail_sel),
    .doubler(cfg.timing_doubler),
    .cycles(trail_len)
  );

  // External clock toggles per timing cycle in half mode, else is held high.
  assign xclk_next = external_clock_half ? ~s_q.xclk : 1'b1;
  // True when the coming timing edge is a rising external clock edge.
  assign rise_next = ~external_clock_half | ~s_q.xclk;
  // Ready is sampled through the synchroniser in both sampling modes;
  // the asynchronous mode only differs in software minimums.
  assign not_ready = cfg.ready_use_enable & ~s_q.rdy_sync;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdy_meta = ready_input;
    s_d.rdy_sync = s_q.rdy_meta;
    if (timing_clock_en)
    begin
      s_d.xclk = xclk_next;
      s_d.cnt = s_q.cnt + ebt_pkg::CNT_BITS'(1);
      case (s_q.state)
        ebt_pkg::ST_IDLE:
        begin
          s_d.strobes = '1;
          if (request.valid)
          begin
            s_d.write = request.write;
            s_d.zone = request.zone;
            s_d.waits = ebt_pkg::WAIT_RESET;
            s_d.cnt = ebt_pkg::CNT_RESET;
            s_d.state = ebt_pkg::ST_ALIGN;
          end
        end
        ebt_pkg::ST_ALIGN:
        begin
          // Wait with strobes idle until the next edge rises.
          s_d.cnt = ebt_pkg::CNT_RESET;
          if (rise_next)
          begin
            s_d.state = ebt_pkg::ST_LEAD;
            s_d.strobes.zone_chip_select_n[s_q.zone] = 1'b0;
          end
        end
        ebt_pkg::ST_LEAD:
        begin
          if (s_q.cnt + ebt_pkg::CNT_BITS'(1) >= lead_len)
          begin
            s_d.state = ebt_pkg::ST_ACTIVE;
            s_d.cnt = ebt_pkg::CNT_RESET;
            s_d.strobes.read_strobe_n = s_q.write;
            s_d.strobes.write_strobe_n = ~s_q.write;
          end
        end
        ebt_pkg::ST_ACTIVE:
        begin
          if (s_q.cnt + ebt_pkg::CNT_BITS'(1) >= active_len
              + ebt_pkg::ACTIVE_EXTRA)
          begin
            if (not_ready)
            begin
              // Hold the phase one more cycle and count the wait.
              s_d.cnt = s_q.cnt;
              s_d.waits = s_q.waits + ebt_pkg::CNT_BITS'(1);
            end
            else
            begin
              s_d.state = ebt_pkg::ST_TRAIL;
              s_d.cnt = ebt_pkg::CNT_RESET;
              s_d.strobes.read_strobe_n = 1'b1;
              s_d.strobes.write_strobe_n = 1'b1;
              if (trail_len == ebt_pkg::CNT_RESET)
              begin
                s_d.state = ebt_pkg::ST_IDLE;
                s_d.strobes = '1;
                s_d.done = 1'b1;
              end
            end
          end
        end
        ebt_pkg::ST_TRAIL:
        begin
          if (s_q.cnt + ebt_pkg::CNT_BITS'(1) >= trail_len)
          begin
            s_d.state = ebt_pkg::ST_IDLE;
            s_d.strobes = '1;
            s_d.done = 1'b1;
          end
        end
        default:
        begin
          s_d.state = ebt_pkg::ST_IDLE;
          s_d.strobes = '1;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.state <= ebt_pkg::ST_IDLE;
      s_q.strobes <= '1;
      s_q.zone <= ebt_pkg::ZONE_RESET;
    end
    else
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign request_ready = (s_q.state == ebt_pkg::ST_IDLE) & timing_clock_en;
  assign external_clock_output = s_q.xclk;
  assign strobes = s_q.strobes;
  assign busy = s_q.state != ebt_pkg::ST_IDLE;
  assign access_done = s_q.done;
  assign inserted_wait_count = s_q.waits;

endmodule : ebt_phase_timer

// >>> rtl/ebt_pkg.sv
// Package: constants and carrier types for the external bus phase timer.
package ebt_pkg;

  // ---------------------------------------------------------------
  // Field widths and zone count
  // ---------------------------------------------------------------
  localparam int ZONE_COUNT = 3;
  localparam int ZONE_BITS = 2;
  localparam int LEAD_BITS = 2;
  localparam int ACTIVE_BITS = 3;
  localparam int TRAIL_BITS = 2;
  localparam int CNT_BITS = 8;

  // ---------------------------------------------------------------
  // Reset values and the active phase extra cycle
  // ---------------------------------------------------------------
  localparam logic [CNT_BITS-1:0] CNT_RESET = 8'h00;
  localparam logic [ZONE_BITS-1:0] ZONE_RESET = 2'h0;
  localparam logic [CNT_BITS-1:0] WAIT_RESET = 8'h00;
  localparam logic [CNT_BITS-1:0] ACTIVE_EXTRA = 8'h01;

  // Per-zone timing configuration.
  typedef struct packed {
    logic [LEAD_BITS-1:0] read_lead_count;
    logic [ACTIVE_BITS-1:0] read_active_count;
    logic [TRAIL_BITS-1:0] read_trail_count;
    logic [LEAD_BITS-1:0] write_lead_count;
    logic [ACTIVE_BITS-1:0] write_active_count;
    logic [TRAIL_BITS-1:0] write_trail_count;
    logic timing_doubler;
    logic ready_use_enable;
    logic ready_sampling_select;
  } ebt_zone_timing_config_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ZONE_BITS-1:0] zone;
  } ebt_request_type;

  typedef struct packed {
    logic read_strobe_n;
    logic write_strobe_n;
    logic [ZONE_COUNT-1:0] zone_chip_select_n;
  } ebt_strobes_type;

  typedef enum {
    ST_IDLE,
    ST_ALIGN,
    ST_LEAD,
    ST_ACTIVE,
    ST_TRAIL
  } ebt_state_type;

endpackage : ebt_pkg

// >>> testbench/ebt_checker.sv
// Assertion checker for the external bus phase timer.
`timescale 1ns/1ps
module ebt_checker (
  // Clock, reset and control
  input wire logic clock,
  input wire logic rst,
  input wire logic timing_clock_en,
  input wire logic external_clock_half,
  input wire ebt_pkg::ebt_zone_timing_config_type
    zone_timing_config [ebt_pkg::ZONE_COUNT],
  input wire ebt_pkg::ebt_request_type request,
  input wire logic request_ready,
  // Pins and status
  input wire logic ready_input,
  input wire logic external_clock_output,
  input wire ebt_pkg::ebt_strobes_type strobes,
  input wire logic busy,
  input wire logic access_done,
  input wire logic [ebt_pkg::CNT_BITS-1:0] inserted_wait_count
);
  // ------
  // Properties
  // ------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [ebt_pkg::ZONE_COUNT-1:0] cs;
  logic rd;
  logic wr;
  assign cs = strobes.zone_chip_select_n;
  assign rd = strobes.read_strobe_n;
  assign wr = strobes.write_strobe_n;
  sequence s_take; request.valid && request_ready; endsequence
  sequence s_lead; ##[1:3] !(&cs); endsequence
  property p_take_lead; s_take |-> s_lead; endproperty
  a_take_lead: assert property (p_take_lead)
    else $error("no chip select after a taken request");
  property p_xclk; $fell(&cs) |-> external_clock_output; endproperty
  a_xclk: assert property (p_xclk)
    else $error("lead did not start on a rising external clock");
  property p_done; $rose(&cs) |-> access_done; endproperty
  a_done: assert property (p_done)
    else $error("no done pulse after chip select release");
  property p_pulse; access_done |=> !access_done; endproperty
  a_pulse: assert property (p_pulse)
    else $error("done pulse longer than one cycle");
  property p_one; rd || wr; endproperty
  a_one: assert property (p_one)
    else $error("read and write strobes low together");
  property p_inside; !(rd && wr) |-> !(&cs); endproperty
  a_inside: assert property (p_inside)
    else $error("strobe active outside chip select");
  property p_zone; $onehot0(~cs); endproperty
  a_zone: assert property (p_zone)
    else $error("more than one zone selected");
  property p_idle; !busy |-> (&cs) && rd && wr; endproperty
  a_idle: assert property (p_idle)
    else $error("strobes active while idle");
  property p_refuse; busy |-> !request_ready; endproperty
  a_refuse: assert property (p_refuse)
    else $error("request accepted while busy");
endmodule : ebt_checker

bind ebt_phase_timer ebt_checker u_chk (.clock(clock), .rst(rst),
  .timing_clock_en(timing_clock_en), .request(request),
  .external_clock_half(external_clock_half), .strobes(strobes),
  .zone_timing_config(zone_timing_config), .busy(busy),
  .request_ready(request_ready), .ready_input(ready_input),
  .external_clock_output(external_clock_output),
  .access_done(access_done), .inserted_wait_count(inserted_wait_count));

// >>> testbench/ebt_ext_memory.sv
// External memory model that answers ready after a set delay.
`timescale 1ns/1ps
module ebt_ext_memory (
  // Clock and bus
  input wire logic clock,
  input wire logic selected,
  input wire logic [3:0] delay,
  // Ready pin
  output logic ready = 1'b0
);
  logic [3:0] age_q = 4'h0;
  // Unselected, the pin is not driven, so it toggles to expose stale use.
  always_ff @(posedge clock)
  begin
    age_q <= selected ? age_q + 4'h1 : 4'h0;
    ready <= selected ? (age_q >= delay) : ~ready;
  end
endmodule : ebt_ext_memory

// >>> testbench/ext_bus_phase_timing_test.sv
// Testbench for the external bus phase timer.
`timescale 1ns/1ps
module ext_bus_phase_timing_test;
  logic clock = 1'b0, rst = 1'b1, ten = 1'b1, half = 1'b0, rdy, xclk;
  logic busy, done, rr;
  logic slow = 1'b0;
  logic [7:0] ws;
  logic [3:0] dly = 4'h0;
  ebt_pkg::ebt_zone_timing_config_type cfg [ebt_pkg::ZONE_COUNT];
  ebt_pkg::ebt_request_type req = '0;
  ebt_pkg::ebt_strobes_type stb;
  int fails = 0, n_tests = 0;
  initial forever #50 clock = ~clock;
  // Slow mode pulses the timing enable on every other clock.
  always @(posedge clock)
    ten <= slow ? ~ten : 1'b1;
  ebt_phase_timer dut (.clock(clock), .rst(rst), .timing_clock_en(ten),
    .external_clock_half(half), .zone_timing_config(cfg), .request(req),
    .request_ready(rr), .ready_input(rdy), .external_clock_output(xclk),
    .strobes(stb), .busy(busy), .access_done(done),
    .inserted_wait_count(ws));
  ebt_ext_memory mem (.clock(clock), .selected(~&stb.zone_chip_select_n),
    .delay(dly), .ready(rdy));
  // ------
  // Shared tasks
  // ------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Phases are measured on the chip select and strobe of the zone.
  task automatic access(input logic [1:0] z, input logic w, input int el,
    input int ea, input int et, input int ew);
    int l, a, t;
    logic s;
    l = 0; a = 0; t = 0;
    @(posedge clock);
    req <= '{1'b1, w, z};
    // The request stands until it is taken on an enabled idle edge.
    do
      @(posedge clock);
    while (!rr);
    req <= '0;
    repeat (40)
    begin
      @(negedge clock);
      s = w ? stb.write_strobe_n : stb.read_strobe_n;
      if (!stb.zone_chip_select_n[z])
      begin
        if (l + a + t == 0) check(16'(xclk), 16'h1);
        if (!s) a++;
        else if (a == 0) l++;
        else t++;
      end
    end
    check(16'(l), 16'(el));
    check(16'(a), 16'(ea + ew));
    check(16'(t), 16'(et));
    check(16'(ws), 16'(ew));
  endtask : access
  // ------
  // Scenarios
  // ------
  task automatic t_plain;
    @(posedge clock);
    cfg[0] <= '{2'h3, 3'h2, 2'h1, 2'h1, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0};
    access(2'h0, 1'b0, 3, 3, 1, 1'b0);
    access(2'h0, 1'b1, 1, 1, 0, 1'b0);
  endtask : t_plain
  task automatic t_double;
    @(posedge clock);
    cfg[1] <= '{2'h1, 3'h0, 2'h0, 2'h2, 3'h3, 2'h3, 1'b1, 1'b0, 1'b0};
    access(2'h1, 1'b1, 4, 7, 6, 1'b0);
    access(2'h1, 1'b0, 2, 1, 0, 1'b0);
  endtask : t_double
  task automatic t_ready;
    @(posedge clock);
    dly <= 4'h6;
    cfg[2] <= '{2'h1, 3'h2, 2'h0, 2'h1, 3'h2, 2'h0, 1'b0, 1'b1, 1'b0};
    access(2'h2, 1'b0, 1, 3, 0, 6);
    @(posedge clock);
    cfg[2].ready_use_enable <= 1'b0;
    access(2'h2, 1'b1, 1, 3, 0, 0);
  endtask : t_ready
  task automatic t_async;
    @(posedge clock);
    dly <= 4'h0;
    cfg[2] <= '{2'h2, 3'h2, 2'h0, 2'h2, 3'h2, 2'h0, 1'b1, 1'b1, 1'b1};
    access(2'h2, 1'b0, 4, 5, 0, 0);
    @(posedge clock);
    dly <= 4'h9;
    access(2'h2, 1'b1, 4, 5, 0, 4);
  endtask : t_async
  // Phases are counted in clocks, so each timing cycle counts twice.
  task automatic t_slow;
    @(posedge clock);
    slow <= 1'b1;
    access(2'h1, 1'b0, 4, 2, 0, 0);
    @(posedge clock);
    slow <= 1'b0;
  endtask : t_slow
  task automatic t_half;
    @(posedge clock);
    half <= 1'b1;
    cfg[0] <= '{2'h0, 3'h1, 2'h1, 2'h1, 3'h1, 2'h1, 1'b0, 1'b0, 1'b0};
    access(2'h0, 1'b0, 1, 2, 1, 1'b0);
    access(2'h0, 1'b1, 1, 2, 1, 1'b0);
  endtask : t_half
  initial
  begin
    cfg = '{default: '0};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_plain();
    t_double();
    t_ready();
    t_async();
    t_slow();
    t_half();
    tally_and_finish();
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule : ext_bus_phase_timing_test
